// ===== tb.sv
// Purpose: Random instruction stream against a reference model
// Assumes: File array modelled here, read combinationally
// Notes: No file-xor right after a write-back, as the design asks
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import xad_pkg::*;
    logic clk_sys_in = 0, rst_b_in = 0, insn_valid_in = 0, zf = XAD_ZERO_RST;
    logic [11:0] insn_in = 12'h000, w;
    logic [7:0] mem [32], mm [32], x, acc = XAD_ACC_RST;
    logic [7:0] dir [3] = '{default: XAD_DIR_RST};
    logic [46:0] exp_q [$];
    logic pv = 0;
    logic [31:0] r;
    int seed = 96, error_cnt = 0, n_compared = 0;
    wire [4:0] fa;
    wire [7:0] wd, ac, da, db, dc;
    wire we, zo;
    wire [7:0] rd = mem[fa];
    xad_exec dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .insn_valid_in(insn_valid_in), .insn_in(insn_in), .file_rdata_in(rd),
        .file_addr_out(fa), .file_wdata_out(wd), .file_we_out(we),
        .acc_out(ac), .zero_flag_out(zo), .dir_a_out(da), .dir_b_out(db),
        .dir_c_out(dc));
    task summarize();
        if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string n, input logic [46:0] s, e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    initial forever #2 clk_sys_in = ~clk_sys_in;
    initial begin
        #20000;
        error_cnt++;
        summarize();
    end
    always @(posedge clk_sys_in) if (we) mem[fa] <= wd;
    always @(posedge clk_sys_in) if (exp_q.size() > 0) begin : mon
        logic [46:0] e;
        e = exp_q.pop_front();
        #1 chk("state", {ac, zo, da, db, dc}, e[46:14]);
        chk("write", {we, we ? wd : 8'h00, we ? fa : 5'h00}, e[13:0]);
    end
    initial begin
        for (int i = 0; i < 32; i++) mem[i] = $random(seed);
        mm = mem;
        repeat (20) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        repeat (500) begin
            @(posedge clk_sys_in);
            r = $random(seed);
            case (r[1:0])
                2'd0: w = {r[4] ? 9'h000 : r[20:12], r[7:5]};
                2'd1: w = {4'hf, r[15:8]};
                2'd2: w = {6'h06, r[13:8]};
                default: w = {4'hf, acc};
            endcase
            if (pv && w[11:6] == 6'h06) w[11:8] = 4'hf;
            insn_in <= w;
            insn_valid_in <= r[31:30] != 2'h0;
            pv = 0;
            x = acc ^ mm[w[4:0]];
            if (r[31:30] == 2'h0) ;
            else if (w[11:3] == 9'h000 && w[2:0] > 3'h4)
                dir[w[2:0] - 3'h5] = acc;
            else if (w[11:8] == 4'hf)
                {acc, zf} = {acc ^ w[7:0], w[7:0] == acc};
            else if (w[11:6] == 6'h06) begin
                zf = x == 8'h00;
                pv = w[5];
                if (w[5]) mm[w[4:0]] = x;
                else acc = x;
            end
            #1 exp_q.push_back({acc, zf, dir[0], dir[1], dir[2], pv,
                pv ? x : 8'h00, pv ? w[4:0] : 5'h00});
        end
        repeat (2) @(posedge clk_sys_in);
        summarize();
    end
endmodule

// ===== xad_dec_if.sv
// Purpose: Decoded instruction bundle between decoder and execute stage
// Assumes: One clock domain
// Notes: Pure combinational carrier
interface xad_dec_if;
    import xad_pkg::*;
    logic is_dir;
    logic is_xlit;
    logic is_xf;
    logic dest_file;
    logic [2:0] dir_sel;
    logic [7:0] literal;
    logic [4:0] faddr;
    modport dec(output is_dir, is_xlit, is_xf, dest_file, dir_sel, literal,
        faddr);
    modport exe(input is_dir, is_xlit, is_xf, dest_file, dir_sel, literal,
        faddr);
endinterface

// ===== xad_decode.sv
// Purpose: Splits one instruction word into decoded fields
// Assumes: Word is stable for the whole instruction cycle
// Notes: No state
module xad_decode
    import xad_pkg::*;
(
    input wire logic [11:0] insn_in,
    xad_dec_if.dec dec
);
    always_comb begin
        dec.is_dir = ((insn_in & XAD_DIR_MASK) == XAD_DIR_CODE)
            && (insn_in[XAD_SEL_MSB:0] >= XAD_DIR_SEL_FIRST);
        dec.is_xlit = (insn_in & XAD_XLIT_MASK) == XAD_XLIT_CODE;
        dec.is_xf = (insn_in & XAD_XF_MASK) == XAD_XF_CODE;
        dec.dest_file = insn_in[XAD_DEST_BIT];
        dec.dir_sel = insn_in[XAD_SEL_MSB:0];
        dec.literal = insn_in[7:0];
        dec.faddr = insn_in[4:0];
    end
endmodule

// ===== xad_exec.sv
// Purpose: Execute stage for direction-load, literal-xor and file-xor
// Assumes: One instruction per clock; file read data is combinational
// Notes: File register array lives outside; written via a one-cycle strobe
// Notes: A file-xor right after a write-back reads the write address
module xad_exec
    import xad_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic insn_valid_in,
    input wire logic [11:0] insn_in,
    input wire logic [7:0] file_rdata_in,
    output logic [4:0] file_addr_out,
    output logic [7:0] file_wdata_out,
    output logic file_we_out,
    output logic [7:0] acc_out,
    output logic zero_flag_out,
    output logic [7:0] dir_a_out,
    output logic [7:0] dir_b_out,
    output logic [7:0] dir_c_out
);
    // ****************************************
    // Decode
    // ****************************************
    xad_dec_if dif();

    xad_decode u_dec (
        .insn_in(insn_in),
        .dec(dif)
    );

    // ****************************************
    // State
    // ****************************************
    // Architectural state
    logic [7:0] acc_q;
    logic [7:0] acc_d;
    logic zero_q;
    logic zero_d;
    logic [7:0] dir_q [XAD_DIR_COUNT];
    logic [7:0] dir_d [XAD_DIR_COUNT];

    // Pending file write-back
    logic [4:0] faddr_q;
    logic [4:0] faddr_d;
    logic [7:0] fwd_q;
    logic [7:0] fwd_d;
    logic fwe_q;
    logic fwe_d;

    // Per-cycle strobes and results
    logic do_dir;
    logic do_xlit;
    logic do_xf;
    logic do_xf_acc;
    logic do_xf_file;
    logic [7:0] lit_result;
    logic lit_zero;
    logic [7:0] file_result;
    logic file_zero;
    logic [1:0] dir_idx;

    // ****************************************
    // Strobes
    // ****************************************
    // A word acts only in a valid cycle; no stall is ever asked for
    // Decode classes never overlap, so at most one of do_dir, do_xlit and do_xf is high
    always_comb begin
        do_dir = insn_valid_in && dif.is_dir;
        do_xlit = insn_valid_in && dif.is_xlit;
        do_xf = insn_valid_in && dif.is_xf;
        do_xf_acc = do_xf && !dif.dest_file;
        do_xf_file = do_xf && dif.dest_file;
    end

    // ****************************************
    // Literal xor
    // ****************************************
    always_comb begin
        lit_result = acc_q ^ dif.literal;
        lit_zero = (lit_result == 8'h00);
    end

    // ****************************************
    // File xor
    // ****************************************
    // Read data arrives in the same cycle from the address port
    always_comb begin
        file_result = acc_q ^ file_rdata_in;
        file_zero = (file_result == 8'h00);
    end

    // ****************************************
    // Direction selector
    // ****************************************
    // Selectors below 5 never raise do_dir, so the wrap is harmless
    // Index 0, 1, 2 stands for selector 5, 6, 7
    always_comb begin
        dir_idx = 2'(dif.dir_sel - XAD_DIR_SEL_FIRST);
    end

    // ****************************************
    // Accumulator
    // ****************************************
    always_comb begin
        acc_d = acc_q;
        if (do_xlit) begin
            acc_d = lit_result;
        end else if (do_xf_acc) begin
            acc_d = file_result;
        end
    end

    // Kept on a file write-back and on a direction load
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            acc_q <= XAD_ACC_RST;
        end else begin
            acc_q <= acc_d;
        end
    end

    // ****************************************
    // Zero flag
    // ****************************************
    // Direction load leaves the flag alone
    always_comb begin
        zero_d = zero_q;
        if (do_xlit) begin
            zero_d = lit_zero;
        end else if (do_xf) begin
            zero_d = file_zero;
        end
    end

    // Updated for both destinations of a file-xor
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            zero_q <= XAD_ZERO_RST;
        end else begin
            zero_q <= zero_d;
        end
    end

    // ****************************************
    // Direction registers
    // ****************************************
    // Only the selected register moves; the others hold
    always_comb begin
        dir_d = dir_q;
        if (do_dir) begin
            dir_d[dir_idx] = acc_q;
        end
    end

    // All direction bits come up as inputs
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < XAD_DIR_COUNT; i++) begin
                dir_q[i] <= XAD_DIR_RST;
            end
        end else begin
            dir_q <= dir_d;
        end
    end

    // ****************************************
    // Write-back request
    // ****************************************
    // The write lands one cycle late so strobe and data leave from flops;
    // the address port shows the write address in that cycle
    // Address and data hold their last values while no write is pending
    always_comb begin
        faddr_d = faddr_q;
        fwd_d = fwd_q;
        fwe_d = 1'b0;
        if (do_xf_file) begin
            faddr_d = dif.faddr;
            fwd_d = file_result;
            fwe_d = 1'b1;
        end
    end

    // ****************************************
    // Write-back register
    // ****************************************
    // Strobe is high for exactly one cycle per write
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            faddr_q <= 5'h00;
            fwd_q <= 8'h00;
            fwe_q <= 1'b0;
        end else begin
            faddr_q <= faddr_d;
            fwd_q <= fwd_d;
            fwe_q <= fwe_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Read address is combinational so the operand arrives the same cycle
    assign file_addr_out = fwe_q ? faddr_q : dif.faddr;
    assign file_wdata_out = fwd_q;
    assign file_we_out = fwe_q;
    assign acc_out = acc_q;
    assign zero_flag_out = zero_q;
    assign dir_a_out = dir_q[0];
    assign dir_b_out = dir_q[1];
    assign dir_c_out = dir_q[2];
endmodule

// ===== xad_monitor.sv
// Purpose: Assertions on the xor and direction-load execute block
// Assumes: Bound to xad_exec, one clock
// Notes: Results are checked one edge after the word is taken
module xad_monitor (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic insn_valid_in,
    input wire logic [11:0] insn_in,
    input wire logic [7:0] file_rdata_in,
    input wire logic [4:0] file_addr_out,
    input wire logic [7:0] file_wdata_out,
    input wire logic file_we_out,
    input wire logic [7:0] acc_out,
    input wire logic zero_flag_out,
    input wire logic [7:0] dir_a_out,
    input wire logic [7:0] dir_b_out,
    input wire logic [7:0] dir_c_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    wire go = rst_b_in & insn_valid_in;
    wire xf = go & (insn_in[11:6] == 6'h06);
    wire [7:0] xr = acc_out ^ file_rdata_in;
    wire [7:0] xl = acc_out ^ insn_in[7:0];
    wire [4:0] fa = insn_in[4:0];
    chk_dir_load:
    assert property (go && insn_in == 12'h006 |=> dir_b_out == $past(acc_out)
        && $stable(zero_flag_out)) else $error("dir load wrong");
    chk_xor_lit:
    assert property (go && insn_in[11:8] == 4'hf |=> acc_out == $past(xl)
        && zero_flag_out == (acc_out == 8'h00)) else $error("xor lit wrong");
    chk_xf_zero:
    assert property (xf |=> zero_flag_out == ($past(xr) == 8'h00))
        else $error("xor file zero wrong");
    chk_xf_acc:
    assert property (xf && !insn_in[5] |=> acc_out == $past(xr) && !file_we_out)
        else $error("xor file to acc wrong");
    chk_xf_file:
    assert property (xf && insn_in[5] |=> file_we_out && $stable(acc_out)
        && file_wdata_out == $past(xr)) else $error("xor file write wrong");
    chk_wr_addr:
    assert property (xf && insn_in[5] |=> file_addr_out == $past(fa))
        else $error("write address wrong");
    chk_we_idle:
    assert property (!(xf && insn_in[5]) |=> !file_we_out)
        else $error("stray file write");
    chk_dir_refused:
    assert property (go && insn_in[11:3] == 9'h000 && insn_in[2:0] < 3'h5
        |=> $stable(dir_a_out) && $stable(dir_b_out) && $stable(dir_c_out))
        else $error("refused dir load moved");
endmodule
bind xad_exec xad_monitor chk_u (.*);

// ===== xad_pkg.sv
// Purpose: Shared constants for the xor and direction-load execution block
// Assumes: 12-bit instruction words, 8-bit data path
// Notes: Encodings are fixed by the instruction set
package xad_pkg;
    localparam int XAD_DATA_W = 8;
    localparam int XAD_INSN_W = 12;
    localparam int XAD_FADDR_W = 5;
    // Instruction encodings and match masks
    localparam logic [11:0] XAD_DIR_MASK = 12'hff8;
    localparam logic [11:0] XAD_DIR_CODE = 12'h000;
    localparam logic [11:0] XAD_XLIT_MASK = 12'hf00;
    localparam logic [11:0] XAD_XLIT_CODE = 12'hf00;
    localparam logic [11:0] XAD_XF_MASK = 12'hfc0;
    localparam logic [11:0] XAD_XF_CODE = 12'h180;
    // Field positions
    localparam int XAD_DEST_BIT = 5;
    localparam int XAD_SEL_MSB = 2;
    // Direction register selectors
    localparam logic [2:0] XAD_DIR_SEL_FIRST = 3'h5;
    localparam int XAD_DIR_COUNT = 3;
    // Reset values
    localparam logic [7:0] XAD_ACC_RST = 8'h00;
    localparam logic [7:0] XAD_DIR_RST = 8'hff;
    localparam logic XAD_ZERO_RST = 1'b0;
endpackage
